// file: include/wbeme_pkg.sv
// package: offsets, field positions and reset values of the write buffer message enables
package wbeme_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_FIRST = 8'h70;
    localparam logic [7:0] OFS_NEXT = 8'h72;
    localparam logic [7:0] OFS_MASK = 8'h74;
    localparam logic [7:0] OFS_SCI = 8'h78;
    localparam logic [7:0] OFS_SMI = 8'h7A;
    localparam logic [7:0] OFS_SERR = 8'h7C;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int NSRC = 4;
    localparam logic [7:0] ENA_RESET = 8'h00;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [7:0] ENA_WMASK = 8'h0F;
    localparam int BIT_DRAM_TO_BUF = 3;
    localparam int BIT_BUS_TO_BUF = 2;
    localparam int BIT_BUF_TO_BUS = 1;
    localparam int BIT_BUF_TO_DRAM = 0;
    // message kind codes, one-hot
    localparam logic [2:0] MSG_SCI = 3'h1;
    localparam logic [2:0] MSG_SMI = 3'h2;
    localparam logic [2:0] MSG_SERR = 3'h4;
endpackage : wbeme_pkg

// file: include/wbeme_flag_if.sv
// interface: error flags and mask between the flag keeper and the message router
`timescale 1ns/1ns
`default_nettype none
interface wbeme_flag_if;
    logic [3:0] first_error_flags;
    logic [3:0] next_error_flags;
    logic [3:0] buffer_error_mask;
    logic [3:0] rise;
    modport keeper (output first_error_flags, output next_error_flags, output rise,
        input buffer_error_mask);
    modport router (input first_error_flags, input next_error_flags, input rise,
        output buffer_error_mask);
endinterface : wbeme_flag_if
`default_nettype wire

// file: hw/wbeme_flags.sv
// module: first and next error flag keeper of the posted write buffer
`timescale 1ns/1ns
`default_nettype none
module wbeme_flags (
    // clock
    input wire logic clock,
    // error events and software clears
    input wire logic [3:0] err_event,
    input wire logic [3:0] clr_first,
    input wire logic [3:0] clr_next,
    // flags towards the router
    wbeme_flag_if.keeper fl
);
    typedef struct packed {
        logic [3:0] first;
        logic [3:0] next;
        logic [3:0] rise;
    } wbeme_flags_st_t;

    wbeme_flags_st_t st_ff;
    wbeme_flags_st_t nxt_st;
    logic [3:0] live;

    // flags are sticky through reset, so no reset reaches this state
    always_comb begin
        live = err_event & ~fl.buffer_error_mask;
        nxt_st = st_ff;
        if (st_ff.first == wbeme_pkg::FLAG_RESET) begin
            // several errors in the first error's cycle all latch
            nxt_st.first = live | (st_ff.first & ~clr_first);
            nxt_st.next = st_ff.next & ~clr_next;
        end else begin
            nxt_st.first = st_ff.first & ~clr_first;
            nxt_st.next = live | (st_ff.next & ~clr_next);
        end
        // set wins over a same-cycle clear; any new setting is a rising edge
        nxt_st.rise = live & ((st_ff.first == wbeme_pkg::FLAG_RESET) ? ~st_ff.first : ~st_ff.next);
    end

    always_ff @(posedge clock) begin
        st_ff <= nxt_st;
    end

    assign fl.first_error_flags = st_ff.first;
    assign fl.next_error_flags = st_ff.next;
    assign fl.rise = st_ff.rise;
endmodule : wbeme_flags
`default_nettype wire

// file: hw/wbeme_top.sv
// module: write buffer error message enables with register port and message strobes
`timescale 1ns/1ns
`default_nettype none
// How it works
// - sci enable register at 0x78, eight bits, resets to zero
// - smi enable register at 0x7A, resets zero, enabled flag raises smi cycle
// - serr enable register at 0x7C, resets zero, enabled flag raises serr cycle
// - sci enable bit 3 gates sci from flag bit 3
// - sci enable bit 2 gates sci from flag bit 2
// - sci enable bit 1 uses flag bit 0, bit 0 uses flag bit 1
// - smi enable bits 3 and 2 gate flags 3 and 2
// - smi enable bits 1 and 0 gate flags 1 and 0
// - serr enable bits 3 and 2 gate flags 3 and 2
// - serr enable bits 1 and 0 gate flags 1 and 0
// - bits 7 to 4 reserved, reset zero, no effect
// - next flags record later errors, sticky through reset, write one clears
// - flag bits: 3 dram-buf, 2 bus-buf, 1 buf-bus, 0 buf-dram
// - masked errors are neither logged nor messaged
module wbeme_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration register port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // buffer error events, one bit per source
    input wire logic [3:0] err_event,
    // hub link special cycle requests, one-cycle pulses
    output logic hub_link_sci,
    output logic hub_link_smi,
    output logic hub_link_serr
);
    typedef struct packed {
        logic [7:0] sci;
        logic [7:0] smi;
        logic [7:0] serr;
        logic [3:0] mask;
        logic [7:0] rdata;
        logic [2:0] msg;
    } wbeme_st_t;

    wbeme_st_t st_ff;
    wbeme_st_t nxt_st;
    wbeme_st_t mask_st_ff;
    logic [3:0] clr_first;
    logic [3:0] clr_next;
    logic [3:0] sci_src;

    wbeme_flag_if fl ();

    // ****************************************
    // flag keeper
    // ****************************************
    wbeme_flags u_flags (
        .clock(clock),
        .err_event(err_event),
        .clr_first(clr_first),
        .clr_next(clr_next),
        .fl(fl)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = cfg_wr && (a == ofs);
    endfunction : hit

    // mask is sticky through reset, so it lives outside the reset state
    always_ff @(posedge clock) begin
        if (hit(cfg_addr, wbeme_pkg::OFS_MASK)) begin
            mask_st_ff.mask <= cfg_wdata[3:0];
        end
    end
    assign fl.buffer_error_mask = mask_st_ff.mask;

    assign clr_first = hit(cfg_addr, wbeme_pkg::OFS_FIRST) ? cfg_wdata[3:0] : 4'h0;
    assign clr_next = hit(cfg_addr, wbeme_pkg::OFS_NEXT) ? cfg_wdata[3:0] : 4'h0;

    // ****************************************
    // enables, readback and message routing
    // ****************************************
    // crossed pairing of the low sci bits kept as the register defines it
    assign sci_src = {fl.rise[3], fl.rise[2], fl.rise[0], fl.rise[1]};

    always_comb begin
        nxt_st = st_ff;
        nxt_st.mask = mask_st_ff.mask;
        if (hit(cfg_addr, wbeme_pkg::OFS_SCI)) begin
            nxt_st.sci = cfg_wdata & wbeme_pkg::ENA_WMASK;
        end
        if (hit(cfg_addr, wbeme_pkg::OFS_SMI)) begin
            nxt_st.smi = cfg_wdata & wbeme_pkg::ENA_WMASK;
        end
        if (hit(cfg_addr, wbeme_pkg::OFS_SERR)) begin
            nxt_st.serr = cfg_wdata & wbeme_pkg::ENA_WMASK;
        end
        nxt_st.rdata = 8'h00;
        if (cfg_rd) begin
            unique case (cfg_addr)
                wbeme_pkg::OFS_FIRST: nxt_st.rdata = {4'h0, fl.first_error_flags};
                wbeme_pkg::OFS_NEXT: nxt_st.rdata = {4'h0, fl.next_error_flags};
                wbeme_pkg::OFS_MASK: nxt_st.rdata = {4'h0, mask_st_ff.mask};
                wbeme_pkg::OFS_SCI: nxt_st.rdata = st_ff.sci;
                wbeme_pkg::OFS_SMI: nxt_st.rdata = st_ff.smi;
                wbeme_pkg::OFS_SERR: nxt_st.rdata = st_ff.serr;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // rise pulses once per flag setting, so no repeat while it stays set
        nxt_st.msg[0] = |(sci_src & st_ff.sci[3:0]);
        nxt_st.msg[1] = |(fl.rise & st_ff.smi[3:0]);
        nxt_st.msg[2] = |(fl.rise & st_ff.serr[3:0]);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_rdata = st_ff.rdata;
    assign hub_link_sci = st_ff.msg[0];
    assign hub_link_smi = st_ff.msg[1];
    assign hub_link_serr = st_ff.msg[2];
endmodule : wbeme_top
`default_nettype wire

// file: verification/wbeme_sva.sv
// checker: strobe gating and read port of the message enables
`timescale 1ns/1ns
`default_nettype none
module wbeme_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    // events and strobes
    input wire logic [3:0] err_event,
    input wire logic hub_link_sci,
    input wire logic hub_link_smi,
    input wire logic hub_link_serr
);
    logic [11:0] en_ff;
    logic [3:0] sci_map;
    // sci low two sources are crossed
    assign sci_map = {en_ff[3:2], en_ff[0], en_ff[1]};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_ff <= 12'h000;
        end else if (cfg_wr) begin
            if (cfg_addr == wbeme_pkg::OFS_SCI) en_ff[3:0] <= cfg_wdata[3:0];
            if (cfg_addr == wbeme_pkg::OFS_SMI) en_ff[7:4] <= cfg_wdata[3:0];
            if (cfg_addr == wbeme_pkg::OFS_SERR) en_ff[11:8] <= cfg_wdata[3:0];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |-> !(hub_link_sci | hub_link_smi | hub_link_serr))
        else $error("strobe during reset");
    a_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
        else $error("read data without read");
    a_rsvd_zero: assert property (cfg_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'h7E |-> !cfg_rdata)
        else $error("unmapped read nonzero");
    a_sci_gate: assert property (hub_link_sci |-> |(sci_map & $past(err_event, 2)))
        else $error("sci without enabled event");
    a_smi_gate: assert property (hub_link_smi |-> |(en_ff[7:4] & $past(err_event, 2)))
        else $error("smi without enabled event");
    a_serr_gate: assert property (hub_link_serr |-> |(en_ff[11:8] & $past(err_event, 2)))
        else $error("serr without enabled event");
    a_smi_single: assert property (hub_link_smi && !$past(err_event) |=> !hub_link_smi)
        else $error("smi repeated");
    cover property (hub_link_sci);
    cover property (hub_link_smi);
    cover property (hub_link_serr);
endmodule : wbeme_sva
`default_nettype wire

// file: verification/wbeme_hub_model.sv
// model: far-end hub counting special cycles of each kind
`timescale 1ns/1ns
`default_nettype none
module wbeme_hub_model (
    // clock and strobes, serr smi sci
    input wire logic clock,
    input wire logic [2:0] msg,
    // counts per kind
    output logic [2:0][7:0] cnt
);
    initial cnt = '0;
    // unknown strobes are not counted, so they show as a shortfall
    always @(posedge clock) begin
        for (int k = 0; k < 3; k++) begin
            if (msg[k] === 1'b1) cnt[k] <= cnt[k] + 8'h01;
        end
    end
endmodule : wbeme_hub_model
`default_nettype wire

// file: verification/wbeme_bench.sv
// bench: register and message checks of the message enables
`timescale 1ns/1ns
`default_nettype none
module wbeme_bench;
    logic clock, rst, cfg_wr, cfg_rd, hub_link_sci, hub_link_smi, hub_link_serr;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, d;
    logic [3:0] err_event;
    logic [2:0][7:0] cnt;
    logic [7:0] ofs [3];
    int err_count, cmp_count, cyc, seed, k, s, m, b;
    int exp_cnt [3];
    wbeme_top uut (.clock, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .err_event, .hub_link_sci, .hub_link_smi, .hub_link_serr);
    wbeme_hub_model hub (.clock, .msg({hub_link_serr, hub_link_smi, hub_link_sci}), .cnt);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic note(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : note
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, v};
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask : wr
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge clock);
        cfg_rd = 1'b0;
        note("register", e, cfg_rdata);
    endtask : chk_reg
    task automatic chk_cnt();
        for (int j = 0; j < 3; j++) note("message count", 8'(exp_cnt[j]), cnt[j]);
    endtask : chk_cnt
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        seed = 32'h8002;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, err_event} = '0;
        rst = 1'b1;
        ofs = '{wbeme_pkg::OFS_SCI, wbeme_pkg::OFS_SMI, wbeme_pkg::OFS_SERR};
        exp_cnt = '{0, 0, 0};
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (k = 0; k < 3; k++) chk_reg(ofs[k], wbeme_pkg::ENA_RESET);
        chk_reg(8'h7E, 8'h00);
        for (int i = 0; i < 24; i++) begin
            {k, s, m, d} = {i % 3, (i / 3) % 4, $random(seed) & 1, 8'($random(seed))};
            // mask first: the flags are sticky and unknown until cleared
            wr(wbeme_pkg::OFS_MASK, 8'(m << s));
            wr(wbeme_pkg::OFS_FIRST, 8'h0F);
            wr(wbeme_pkg::OFS_NEXT, 8'h0F);
            wr(ofs[k], d);
            chk_reg(ofs[k], d & wbeme_pkg::ENA_WMASK);
            b = (k == 0 && s < 2) ? 1 - s : s;
            // first and next flag each raise one strobe, the third finds both set
            repeat (3) begin
                @(negedge clock) err_event = 4'(1 << s);
                @(negedge clock) err_event = 4'h0;
                repeat (3) @(negedge clock);
            end
            exp_cnt[k] += (m == 0 && d[b]) ? 2 : 0;
            chk_cnt();
            chk_reg(wbeme_pkg::OFS_FIRST, m ? 8'h00 : 8'(1 << s));
            chk_reg(wbeme_pkg::OFS_NEXT, m ? 8'h00 : 8'(1 << s));
            wr(ofs[k], 8'h00);
            $display("test %0d done", i);
        end
        // enables clear on a mid-run reset while the sticky flags survive it
        wr(wbeme_pkg::OFS_MASK, 8'h00);
        wr(wbeme_pkg::OFS_FIRST, 8'h0F);
        wr(wbeme_pkg::OFS_NEXT, 8'h0F);
        @(negedge clock) err_event = 4'h4;
        @(negedge clock) err_event = 4'h0;
        // enable written only after the flag rose, so no message is due
        wr(wbeme_pkg::OFS_SMI, 8'h0F);
        @(negedge clock) rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        chk_reg(wbeme_pkg::OFS_SMI, wbeme_pkg::ENA_RESET);
        chk_reg(wbeme_pkg::OFS_FIRST, 8'h04);
        chk_cnt();
        $display("test reset done");
        tally_and_finish();
    end
endmodule : wbeme_bench
bind wbeme_top wbeme_sva chk (.clock, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .err_event, .hub_link_sci, .hub_link_smi, .hub_link_serr);
`default_nettype wire
